// file: port_config_wake.sv
// Port drive configuration, comparator routing and stop-mode wake control behind AXI4-Lite.
//
// Notes on behaviour
// - Configuration bit 0 set puts the two comparator outputs on port 3 pins 4 and 7, clear gives them back.
// - Configuration bit 1 set makes port 1 push-pull, clear makes it open-drain.
// - Configuration bit 2 set makes port 0 push-pull, clear makes it open-drain.
// - The port configuration register takes writes but always reads back as zero.
// - The port configuration register sits at index 00.
// - Wake field bits 4..2 pick the wake source: none, NAND of port2 low nibble, NAND of port2, NOR or NAND of port3 1..3.
// - Codes 5, 6 and 7 are NOR and NAND of port3 1..3 with port0 bits 0 and 7, and NAND of port3 1..3 with port2 0..2.
// - Reset loads the wake field with 000 so only reset ends stop mode until software picks a source.
// - A pin set as an output takes no part in the wake combination.
// - In the wake register at index 0B bits 6..0 are write-only and bit 7 is read-only.
// - Port 3 pins 1..3 only count for wake while they are in digital input mode.
`timescale 1ns/1ps
`include "port_wake_params.svh"
module port_config_wake (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // AXI4-Lite write address and data
  input  wire logic [7:0] awaddr,
  input  wire logic       awvalid,
  output logic            awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0] wstrb,
  input  wire logic       wvalid,
  output logic            wready,
  // AXI4-Lite write response
  output logic [1:0]      bresp,
  output logic            bvalid,
  input  wire logic       bready,
  // AXI4-Lite read
  input  wire logic [7:0] araddr,
  input  wire logic       arvalid,
  output logic            arready,
  output logic [31:0]     rdata,
  output logic [1:0]      rresp,
  output logic            rvalid,
  input  wire logic       rready,
  // Port 0
  input  wire logic [7:0] p0_out_data,
  input  wire logic [7:0] p0_dir,
  input  wire logic [7:0] p0_pin_in,
  output logic [7:0]      p0_pin_out,
  output logic [7:0]      p0_pin_oe,
  // Port 1
  input  wire logic [7:0] p1_out_data,
  input  wire logic [7:0] p1_dir,
  output logic [7:0]      p1_pin_out,
  output logic [7:0]      p1_pin_oe,
  // Port 2
  input  wire logic [7:0] p2_dir,
  input  wire logic [7:0] p2_pin_in,
  // Port 3
  input  wire logic [3:1] p3_pin_in,
  input  wire logic       p3_digital_mode,
  input  wire logic [7:4] p3_out_data,
  input  wire logic [1:0] comp_out,
  output logic [7:4]      p3_pin_out,
  // Stop mode
  input  wire logic       stop_enter,
  output logic            stop_mode,
  output logic            stop_exit
);
  ////////////////////////////////////////////////////////////////////////////////
  port_wake_pkg::wr_state_type    wr_q;
  port_wake_pkg::power_state_type pwr_q;
  port_wake_pkg::wake_src_type    wake_src_q;
  port_wake_pkg::wake_pins_type   pins_raw, pins_s;
  logic [2:0]  cfg_q;
  logic        recovered_q;
  logic        aw_got_q, w_got_q;
  logic [5:0]  aw_idx_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wake;
  logic        do_write;
  logic [5:0]  ar_idx;

  function automatic logic mapped(input logic [5:0] idx);
    mapped = (idx == `CFG_IDX) || (idx == `WAKE_IDX) || (idx == `STAT_IDX);
  endfunction : mapped

  // Returns output enable in the upper byte and pin level in the lower byte.
  function automatic logic [15:0] drive(input logic pp, input logic [7:0] dir, input logic [7:0] data);
    drive = {dir & (pp ? 8'hFF : ~data), pp ? data : 8'h00};
  endfunction : drive

  ////////////////////////////////////////////////////////////////////////////////
  // Address and data are captured separately so either may arrive first.
  assign awready  = !aw_got_q && (wr_q == port_wake_pkg::WR_IDLE);
  assign wready   = !w_got_q && (wr_q == port_wake_pkg::WR_IDLE);
  assign do_write = aw_got_q && w_got_q && (wr_q == port_wake_pkg::WR_IDLE);
  assign ar_idx   = araddr[7:2];
  assign arready  = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      aw_idx_q <= 6'h00;
    end else if (awvalid && awready) begin
      aw_got_q <= 1'b1;
      aw_idx_q <= awaddr[7:2];
    end else if (do_write) begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_got_q  <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && wready) begin
      w_got_q  <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (do_write) begin
      w_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q   <= port_wake_pkg::WR_IDLE;
      bvalid <= 1'b0;
      bresp  <= `RESP_OKAY;
    end else begin
      case (wr_q)
        port_wake_pkg::WR_IDLE: begin
          if (do_write) begin
            wr_q   <= port_wake_pkg::WR_RESP;
            bvalid <= 1'b1;
            bresp  <= mapped(aw_idx_q) ? `RESP_OKAY : `RESP_SLVERR;
          end
        end
        port_wake_pkg::WR_RESP: begin
          if (bready) begin
            wr_q   <= port_wake_pkg::WR_IDLE;
            bvalid <= 1'b0;
          end
        end
        default: begin
          wr_q   <= port_wake_pkg::WR_IDLE;
          bvalid <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration storage; only the low byte lane carries these bits.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= `CFG_RESET;
    end else if (do_write && w_strb_q[0] && aw_idx_q == `CFG_IDX) begin
      cfg_q <= w_data_q[2:0];
    end
  end

  // The reserved low bits are not stored, so a stray one written there has no effect.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wake_src_q <= port_wake_pkg::wake_src_type'(`WAKE_SRC_RESET);
    end else if (do_write && w_strb_q[0] && aw_idx_q == `WAKE_IDX) begin
      wake_src_q <= port_wake_pkg::wake_src_type'(w_data_q[`WAKE_SRC_MSB:`WAKE_SRC_LSB]);
    end
  end

  // Reads: configuration reads zero, wake register shows only the recovery flag.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= `RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp  <= mapped(ar_idx) ? `RESP_OKAY : `RESP_SLVERR;
      case (ar_idx)
        `CFG_IDX:  rdata <= 32'h0000_0000;
        `WAKE_IDX: rdata <= {24'h00_0000, recovered_q, 7'h00};
        `STAT_IDX: rdata <= {27'h000_0000, wake_src_q, wake, stop_mode};
        default:   rdata <= 32'h0000_0000;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive is registered so the pads see no decode glitches.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      p0_pin_out <= 8'h00;
      p0_pin_oe  <= 8'h00;
      p1_pin_out <= 8'h00;
      p1_pin_oe  <= 8'h00;
      p3_pin_out <= 4'h0;
    end else begin
      {p0_pin_oe, p0_pin_out} <= drive(cfg_q[`CFG_P0_PP_BIT], p0_dir, p0_out_data);
      {p1_pin_oe, p1_pin_out} <= drive(cfg_q[`CFG_P1_PP_BIT], p1_dir, p1_out_data);
      p3_pin_out[6:5] <= p3_out_data[6:5];
      p3_pin_out[4]   <= cfg_q[`CFG_COMP_BIT] ? comp_out[0] : p3_out_data[4];
      p3_pin_out[7]   <= cfg_q[`CFG_COMP_BIT] ? comp_out[1] : p3_out_data[7];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  assign pins_raw = '{p0: p0_pin_in, p2: p2_pin_in, p3: p3_pin_in};

  input_sync u_sync (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .pins_in   (pins_raw),
    .pins_sync (pins_s)
  );

  wake_source_select u_wake (
    .pins            (pins_s),
    .p0_dir          (p0_dir),
    .p2_dir          (p2_dir),
    .p3_digital_mode (p3_digital_mode),
    .src             (wake_src_q),
    .wake            (wake)
  );

  assign stop_mode = (pwr_q == port_wake_pkg::PWR_STOP);

  // Recovery flag clears on the next stop entry, which cannot coincide with an exit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwr_q       <= port_wake_pkg::PWR_RUN;
      stop_exit   <= 1'b0;
      recovered_q <= 1'b0;
    end else begin
      stop_exit <= 1'b0;
      case (pwr_q)
        port_wake_pkg::PWR_RUN: begin
          if (stop_enter) begin
            pwr_q       <= port_wake_pkg::PWR_STOP;
            recovered_q <= 1'b0;
          end
        end
        port_wake_pkg::PWR_STOP: begin
          if (wake) begin
            pwr_q       <= port_wake_pkg::PWR_RUN;
            stop_exit   <= 1'b1;
            recovered_q <= 1'b1;
          end
        end
        default: pwr_q <= port_wake_pkg::PWR_RUN;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_comp_route: assert property (cfg_q[`CFG_COMP_BIT] |=> p3_pin_out[4] == $past(comp_out[0])
    && p3_pin_out[7] == $past(comp_out[1])) else $error("comparator not routed to port 3");
  a_p1_drive: assert property (##1 $past(cfg_q[`CFG_P1_PP_BIT]) == 1'b0 |-> (p1_pin_out == 8'h00)
    && (p1_pin_oe == ($past(p1_dir) & ~$past(p1_out_data)))) else $error("port 1 open-drain drive wrong");
  a_p0_drive: assert property (##1 $past(cfg_q[`CFG_P0_PP_BIT]) |->
    p0_pin_out == $past(p0_out_data) && p0_pin_oe == $past(p0_dir)) else $error("port 0 push-pull drive wrong");
  a_cfg_readzero: assert property (arvalid && arready && ar_idx == `CFG_IDX |=>
    rvalid && rdata == 32'h0000_0000) else $error("configuration register readable");
  a_cfg_decode: assert property (do_write && w_strb_q[0] && aw_idx_q == `CFG_IDX |=>
    cfg_q == $past(w_data_q[2:0])) else $error("configuration write lost");
  a_wake_reset: assert property (!$past(aresetn) |-> wake_src_q == port_wake_pkg::SRC_POR_ONLY
    && !wake) else $error("wake source not cleared by reset");
  a_out_ignored: assert property (wake_src_q == port_wake_pkg::SRC_P2_LOW4 && p2_dir[3:0] == 4'hF
    |-> !wake) else $error("output pin used as wake source");
  a_wake_readback: assert property (arvalid && arready && ar_idx == `WAKE_IDX ##1 rvalid
    |-> rdata[6:0] == 7'h00 && rdata[7] == $past(recovered_q)) else $error("wake register readback wrong");
  a_analog_off: assert property (!p3_digital_mode && (wake_src_q == port_wake_pkg::SRC_P3_NAND
    || wake_src_q == port_wake_pkg::SRC_P3_NOR) |-> !wake) else $error("analog port 3 pin woke the part");
  a_stop_exit: assert property (stop_mode && wake |=> !stop_mode && stop_exit && recovered_q
    ##1 !stop_exit) else $error("stop mode not ended by wake");
  a_stop_hold: assert property (stop_mode && !wake |=> stop_mode) else $error("stop mode left without wake");
  a_src_sel: assert property (wake_src_q == port_wake_pkg::SRC_P2_ALL8 && p2_dir == 8'h00
    && pins_s.p2 == 8'hFF |-> !wake) else $error("NAND of port 2 active with all pins high");
endmodule : port_config_wake

// file: port_wake_params.svh
// Register indices, field positions and reset values of the port configuration and wake block.
`ifndef PORT_WAKE_PARAMS_SVH
`define PORT_WAKE_PARAMS_SVH
`define CFG_IDX        6'h00
`define WAKE_IDX       6'h0B
`define STAT_IDX       6'h0C
`define CFG_COMP_BIT   0
`define CFG_P1_PP_BIT  1
`define CFG_P0_PP_BIT  2
`define WAKE_SRC_MSB   4
`define WAKE_SRC_LSB   2
`define WAKE_FLAG_BIT  7
`define CFG_RESET      3'h0
`define WAKE_SRC_RESET 3'h0
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// file: port_wake_pkg.sv
// Types shared by the port configuration and wake source logic.
package port_wake_pkg;
  typedef enum logic [2:0] {
    SRC_POR_ONLY  = 3'h0,
    SRC_P2_LOW4   = 3'h1,
    SRC_P2_ALL8   = 3'h2,
    SRC_P3_NOR    = 3'h3,
    SRC_P3_NAND   = 3'h4,
    SRC_P3P0_NOR  = 3'h5,
    SRC_P3P0_NAND = 3'h6,
    SRC_P3P2_NAND = 3'h7
  } wake_src_type;

  typedef enum logic [1:0] {
    PWR_RUN  = 2'b01,
    PWR_STOP = 2'b10
  } power_state_type;

  typedef enum logic [1:0] {
    WR_IDLE = 2'b01,
    WR_RESP = 2'b10
  } wr_state_type;

  typedef struct packed {
    logic [7:0] p0;
    logic [7:0] p2;
    logic [3:1] p3;
  } wake_pins_type;
endpackage : port_wake_pkg

// file: input_sync.sv
// Two-stage synchroniser for the pins that may end stop mode.
`timescale 1ns/1ps
module input_sync (
  // Clock and reset
  input  wire logic                          aclk,
  input  wire logic                          aresetn,
  // Pins in and synchronised copy out
  input  wire port_wake_pkg::wake_pins_type  pins_in,
  output port_wake_pkg::wake_pins_type       pins_sync
);
  port_wake_pkg::wake_pins_type meta_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q    <= '1;
      pins_sync <= '1;
    end else begin
      meta_q    <= pins_in;
      pins_sync <= meta_q;
    end
  end
endmodule : input_sync

// file: wake_source_select.sv
// Combines the selected wake pins into one wake request, leaving out pins that drive.
`timescale 1ns/1ps
module wake_source_select (
  // Synchronised pins and their directions
  input  wire port_wake_pkg::wake_pins_type pins,
  input  wire logic [7:0]                   p0_dir,
  input  wire logic [7:0]                   p2_dir,
  input  wire logic                         p3_digital_mode,
  // Selection and result
  input  wire port_wake_pkg::wake_src_type  src,
  output logic                              wake
);
  // An excluded input is forced to the neutral value of the gate.
  function automatic logic nand_q(input logic [9:0] v, input logic [9:0] ex);
    nand_q = ~&(v | ex);
  endfunction : nand_q

  // With every input excluded a NOR would read as active, so it is held off.
  function automatic logic nor_q(input logic [9:0] v, input logic [9:0] ex);
    nor_q = (~&ex) & ~|(v & ~ex);
  endfunction : nor_q

  logic [2:0] p3_ex;
  logic [9:0] v3, e3, v30, e30, v32, e32, v24, e24, v28, e28;

  always_comb begin
    p3_ex = {3{~p3_digital_mode}};
    v3  = {7'h7F, pins.p3};
    e3  = {7'h7F, p3_ex};
    v30 = {5'h1F, pins.p3, pins.p0[7], pins.p0[0]};
    e30 = {5'h1F, p3_ex, p0_dir[7], p0_dir[0]};
    v32 = {4'hF, pins.p3, pins.p2[2:0]};
    e32 = {4'hF, p3_ex, p2_dir[2:0]};
    v24 = {6'h3F, pins.p2[3:0]};
    e24 = {6'h3F, p2_dir[3:0]};
    v28 = {2'h3, pins.p2};
    e28 = {2'h3, p2_dir};
    case (src)
      port_wake_pkg::SRC_POR_ONLY:  wake = 1'b0;
      port_wake_pkg::SRC_P2_LOW4:   wake = nand_q(v24, e24);
      port_wake_pkg::SRC_P2_ALL8:   wake = nand_q(v28, e28);
      port_wake_pkg::SRC_P3_NOR:    wake = nor_q(v3, e3);
      port_wake_pkg::SRC_P3_NAND:   wake = nand_q(v3, e3);
      port_wake_pkg::SRC_P3P0_NOR:  wake = nor_q(v30, e30);
      port_wake_pkg::SRC_P3P0_NAND: wake = nand_q(v30, e30);
      port_wake_pkg::SRC_P3P2_NAND: wake = nand_q(v32, e32);
      default:                      wake = 1'b0;
    endcase
  end
endmodule : wake_source_select

// file: pin_world.sv
// Model of the world outside the pads: external levels on port 0 and pull-ups on released port 1 lines.
`timescale 1ns/1ps
module pin_world (
  // Port 0 pads
  input  wire logic [7:0] p0_pin_out,
  input  wire logic [7:0] p0_pin_oe,
  input  wire logic [7:0] p0_ext,
  output logic      [7:0] p0_pin_in,
  // Port 1 pads
  input  wire logic [7:0] p1_pin_out,
  input  wire logic [7:0] p1_pin_oe,
  output logic      [7:0] p1_level
);
  // A released port 1 line floats up to its pull-up and a released port 0 line follows p0_ext, never keeping the last driven level.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      p0_pin_in[i] = p0_pin_oe[i] ? p0_pin_out[i] : p0_ext[i];
      p1_level[i]  = p1_pin_oe[i] ? p1_pin_out[i] : 1'b1;
    end
  end
endmodule : pin_world

// file: tb.sv
// Self-checking testbench of the port configuration and wake block.
`timescale 1ns/1ps
`include "port_wake_params.svh"
module tb;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, p3_digital_mode, stop_enter, stop_mode, stop_exit;
  logic [7:0]  awaddr, araddr, p0_out_data, p0_dir, p0_pin_in, p0_pin_out, p0_pin_oe, p0_ext;
  logic [7:0]  p1_out_data, p1_dir, p1_pin_out, p1_pin_oe, p1_level, p2_dir, p2_pin_in;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, comp_out, resp;
  logic [3:1]  p3_pin_in;
  logic [7:4]  p3_out_data, p3_pin_out, p3_exp;
  int          err_count, checks_done, cyc, n;
  localparam logic [7:0] CFG_A  = {`CFG_IDX, 2'b00};
  localparam logic [7:0] WAKE_A = {`WAKE_IDX, 2'b00};
  localparam logic [7:0] STAT_A = {`STAT_IDX, 2'b00};
  // Pin patterns: p0, p2, p3, p0 dir, p2 dir, digital mode, and which wake codes fire.
  localparam logic [55:0] PAT [11] = '{
    56'hFFFF0700000100, 56'h000000000001FE, 56'hFFF70700000106, 56'hFF7F0700000104,
    56'h7FFF0700000140, 56'hFFFB0700000186, 56'hFFFF05000001D0, 56'hFFFF00000001D8,
    56'h000000FFFF0000, 56'h000000000F01FC, 56'hFFFF0000000000};

  port_config_wake u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .p0_out_data(p0_out_data), .p0_dir(p0_dir), .p0_pin_in(p0_pin_in), .p0_pin_out(p0_pin_out),
    .p0_pin_oe(p0_pin_oe), .p1_out_data(p1_out_data), .p1_dir(p1_dir), .p1_pin_out(p1_pin_out),
    .p1_pin_oe(p1_pin_oe), .p2_dir(p2_dir), .p2_pin_in(p2_pin_in), .p3_pin_in(p3_pin_in),
    .p3_digital_mode(p3_digital_mode), .p3_out_data(p3_out_data), .comp_out(comp_out),
    .p3_pin_out(p3_pin_out), .stop_enter(stop_enter), .stop_mode(stop_mode), .stop_exit(stop_exit));

  pin_world u_pins (.p0_pin_out(p0_pin_out), .p0_pin_oe(p0_pin_oe), .p0_ext(p0_ext),
    .p0_pin_in(p0_pin_in), .p1_pin_out(p1_pin_out), .p1_pin_oe(p1_pin_oe), .p1_level(p1_level));

  always #25 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic do_reset;
    aresetn <= 1'b0;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // The trailing edge keeps a following call from driving a handshake twice in one step.
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    bit aw_done;
    bit w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_done && wready === 1'b1) begin
        w_done = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  task automatic pulse_stop;
    stop_enter <= 1'b1;
    @(posedge aclk);
    stop_enter <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask : pulse_stop

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'h0;
    p0_out_data = 8'hA5; p0_dir = 8'h00; p0_ext = 8'hFF; p1_out_data = 8'h3C; p1_dir = 8'hFF;
    p2_dir = 8'h00; p2_pin_in = 8'h00; p3_pin_in = 3'h0; p3_digital_mode = 1'b1;
    p3_out_data = 4'hA; comp_out = 2'b01; stop_enter = 1'b0;
    do_reset();
    // With the wake field at its reset value, low pins must not end stop mode.
    pulse_stop();
    repeat (10) @(posedge aclk);
    check("stop_held", stop_mode, 1'b1);
    $display("test reset_wake done");
    do_reset();
    p0_dir <= 8'hFF;
    for (int c = 0; c < 8; c++) begin
      axi_write(CFG_A, c);
      check("cfg_bresp", resp, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      p3_exp = c[0] ? {comp_out[1], p3_out_data[6:5], comp_out[0]} : p3_out_data;
      check("p3_out", p3_pin_out, p3_exp);
      check("p1_out", p1_pin_out, c[1] ? 8'h3C : 8'h00);
      check("p1_oe", p1_pin_oe, c[1] ? 8'hFF : 8'hC3);
      check("p1_level", p1_level, 8'h3C);
      check("p0_out", p0_pin_out, c[2] ? 8'hA5 : 8'h00);
      check("p0_oe", p0_pin_oe, c[2] ? 8'hFF : 8'h5A);
      axi_read(CFG_A);
      check("cfg_read", rd, 32'h0);
      check("cfg_rresp", resp, `RESP_OKAY);
    end
    axi_write(8'h3C, 32'h7);
    check("unmapped_bresp", resp, `RESP_SLVERR);
    axi_read(8'h3C);
    check("unmapped_rdata", rd, 32'h0);
    check("unmapped_rresp", resp, `RESP_SLVERR);
    $display("test port_config done");
    for (int p = 0; p < 11; p++) begin
      p0_ext <= PAT[p][55:48];
      p2_pin_in <= PAT[p][47:40];
      p3_pin_in <= PAT[p][34:32];
      p0_dir <= PAT[p][31:24];
      p2_dir <= PAT[p][23:16];
      p3_digital_mode <= PAT[p][8];
      repeat (4) @(posedge aclk);
      for (int k = 0; k < 8; k++) begin
        // Reserved bits 1 and 0 are always written as zero.
        axi_write(WAKE_A, {27'h0, k[2:0], 2'b00});
        axi_read(STAT_A);
        check("wake_src", rd[4:2], k[2:0]);
        check("wake_req", rd[1], PAT[p][k]);
      end
    end
    $display("test wake_sources done");
    p0_dir <= 8'h00;
    p2_dir <= 8'h00;
    p2_pin_in <= 8'hFF;
    axi_write(WAKE_A, 32'h4);
    pulse_stop();
    check("stop_entered", stop_mode, 1'b1);
    axi_read(WAKE_A);
    check("wake_read", rd, 32'h0);
    p2_pin_in <= 8'hFE;
    n = 0;
    while (n < 10) begin
      @(posedge aclk);
      n++;
      #1;
      if (stop_exit === 1'b1) break;
    end
    check("exit_delay", n, 3);
    check("stop_left", stop_mode, 1'b0);
    // Back onto the clock edge so the bus task drives right after it.
    @(posedge aclk);
    axi_read(WAKE_A);
    check("recovered_flag", rd, 32'h80);
    $display("test stop_recovery done");
    tally_and_finish();
  end
endmodule : tb
